// [common/dirp_pkg.sv]
// Shared constants and types of the decode, issue and return predict block
package dirp_pkg;
   // Instruction fields
   localparam logic [1:0] OP_CALL = 2'h1;
   localparam logic [1:0] OP_ARITH = 2'h2;
   localparam logic [1:0] OP_MEM = 2'h3;
   localparam logic [5:0] OP3_FMA = 6'h37;
   localparam logic [5:0] OP3_JMPL = 6'h38;
   localparam logic [5:0] OP3_FPOP1 = 6'h34;
   localparam logic [5:0] OP3_FPOP2 = 6'h35;
   localparam int OP_LSB = 30;
   localparam int RD_LSB = 25;
   localparam int OP3_LSB = 19;
   localparam int RS1_LSB = 14;
   localparam int IMM_BIT = 13;
   localparam int RS3_LSB = 9;
   localparam int VAR_LSB = 7;
   localparam int SIZE_LSB = 5;
   localparam logic [1:0] SIZE_NONE = 2'h0;
   localparam logic [1:0] SIZE_QUAD = 2'h3;
   localparam logic [4:0] REG_LINK = 5'hF;
   localparam logic [4:0] REG_RET = 5'h1F;
   localparam logic [4:0] REG_ZERO = 5'h0;
   localparam logic [12:0] RET_IMM = 13'h8;
   localparam logic [63:0] RET_OFFSET = 64'h8;
   localparam logic [63:0] LANE_STEP = 64'h4;
   // Pipeline shape and resources
   localparam int ISSUE_W = 4;
   localparam int UNITS = 4;
   localparam int RAS_DEPTH = 8;
   localparam int RAS_PTR_W = 3;
   localparam logic [7:0] PIPE_STAGES = 8'hF;
   localparam logic [1:0] REDIRECT_CYC = 2'h2;
   localparam logic [7:0] CSE_TOTAL = 8'h10;
   localparam logic [7:0] GR_TOTAL = 8'h20;
   localparam logic [7:0] FR_TOTAL = 8'h20;
   localparam logic [7:0] RS_TOTAL = 8'h8;
   localparam logic [7:0] MP_TOTAL = 8'h4;
   // Register map
   localparam logic [11:0] ADDR_CTRL = 12'h000;
   localparam logic [11:0] ADDR_STAT = 12'h004;
   localparam logic [11:0] ADDR_MISP = 12'h008;
   localparam logic [11:0] ADDR_EXC = 12'h00C;
   localparam int CTRL_FPU_BIT = 0;
   localparam int CTRL_AM_BIT = 1;
   localparam logic [1:0] CTRL_RESET = 2'h0;

   typedef enum logic [1:0] {
      CLS_ALU = 2'h0,
      CLS_FP = 2'h1,
      CLS_MEM = 2'h2,
      CLS_NONE = 2'h3
   } dirp_cls_t;

   typedef enum logic [1:0] {
      ST_RUN = 2'h0,
      ST_BACKUP = 2'h1
   } dirp_st_t;

   typedef struct packed {
      logic valid;
      logic [3:0] lane_valid;
      logic [63:0] pc;
      logic [3:0][31:0] word;
   } dirp_fetch_t;

   typedef struct packed {
      logic valid;
      logic illegal;
      logic fp_dis;
      logic fma;
      logic fsr_upd;
      logic [4:0] rs3;
      logic [1:0] var_sel;
      logic [1:0] size;
      dirp_cls_t cls;
      logic [1:0] unit;
      logic [3:0] tag;
      logic link_we;
      logic [4:0] link_rd;
      logic [63:0] link_val;
   } dirp_uop_t;

   typedef struct packed {
      logic valid;
      logic misp;
      logic [63:0] target;
   } dirp_cmp_t;

   typedef struct packed {
      logic valid;
      logic [3:0] tag;
   } dirp_fault_t;
endpackage

// [verilog/dirp_ras.sv]
// Return address stack: circular, newest entry on top
`timescale 1ns/100ps
module dirp_ras (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic push,
   input wire logic pop,
   input wire logic [63:0] push_addr,
   output logic [63:0] top
);
   import dirp_pkg::*;

   typedef struct packed {
      logic [RAS_DEPTH-1:0][63:0] ent;
      logic [RAS_PTR_W-1:0] ptr;
   } dirp_ras_st_t;

   dirp_ras_st_t s;
   dirp_ras_st_t next_s;

   // Wrapping pointer: an overflowing push silently replaces the oldest entry
   always_comb begin
      next_s = s;
      if (push) begin
         next_s.ent[s.ptr] = push_addr;
         next_s.ptr = s.ptr + 1'b1;
      end else if (pop) begin
         // Empty pop just reads a stale slot; nothing repairs it, a wrong guess shows up as a misprediction at completion
         next_s.ptr = s.ptr - 1'b1;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign top = s.ent[s.ptr - 1'b1];

   property p_push_top;
      @(posedge pclk) disable iff (!presetn) push |=> top == $past(push_addr);
   endproperty
   a_push_top: assert property (p_push_top) else $error("pushed address not on top");
endmodule // dirp_ras

// [verilog/dirp_core.sv]
// Decode, issue, resource tracking and return prediction front end
`timescale 1ns/100ps
// How it works
// - op 2, op3 37 selects multiply-add format
// - Bits 13:9 give third FP source
// - Bits 8:7 select the variant
// - Bits 6:5 give operand precision
// - Precision 00 or 11 is illegal
// - FPU off traps; otherwise status updates
// - Reserved encodings are illegal, not unfinished
// - Address mask zeroes upper link bits
// - Call or link to r15 pushes PC+8
// - Return idioms predict top, then pop
// - Misprediction discards path, resumes at target
// - Stack overflow overwrites oldest entries
// - Pipeline has fifteen stages
// - Fetch runs ahead; prefetch when buffer full
// - Four-wide issue, stations per unit
// - Allocate at issue, release at write; stations release at dispatch
// - Exception flushes in-flight work and resources
// - Dispatch when operands known, unit free
// - Exception frees memory ports; cache continues
// - Faults signalled in order at completion; ras_err raises at once
module dirp_core (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire dirp_pkg::dirp_fetch_t fetch,
   output logic fetch_ready,
   output logic pf_req,
   output logic [63:0] pf_pc,
   output dirp_pkg::dirp_uop_t [3:0] uop,
   output logic pred_valid,
   output logic [63:0] pred_pc,
   input wire logic [3:0] src_ready,
   input wire logic [3:0] unit_idle,
   output logic [3:0] dispatch,
   input wire dirp_pkg::dirp_cmp_t cmp,
   input wire dirp_pkg::dirp_fault_t fault,
   input wire logic ras_err,
   output logic exc,
   output logic redirect_valid,
   output logic [63:0] redirect_pc
);
   import dirp_pkg::*;

   typedef struct packed {
      dirp_st_t st;
      logic [1:0] wait_cnt;
      logic [1:0] ctrl;
      logic [3:0] buf_v;
      logic [63:0] buf_pc;
      logic [3:0][31:0] buf_w;
      logic fetch_ready;
      logic pf_req;
      logic [63:0] pf_pc;
      dirp_uop_t [3:0] uo;
      logic pred_valid;
      logic [63:0] pred_pc;
      logic redirect;
      logic [63:0] redirect_pc;
      logic exc;
      logic [3:0] head;
      logic [3:0] tail;
      logic [7:0] used;
      logic [15:0] ent_exc;
      dirp_cls_t [15:0] ent_cls;
      logic [7:0] free_gr;
      logic [7:0] free_fr;
      logic [7:0] free_mp;
      logic [3:0][7:0] free_rs;
      logic [3:0] dispatch;
      logic [15:0] misp_cnt;
      logic [15:0] exc_cnt;
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
   } dirp_core_st_t;

   dirp_core_st_t s;
   dirp_core_st_t next_s;

   ////////////////////////////////////////////////////////////////////////////////
   // Per-lane decode

   function automatic dirp_uop_t dirp_decode(input logic [31:0] w, input logic [63:0] pc,
                                             input logic fpu_on, input logic am,
                                             input logic odd);
      dirp_uop_t u;
      logic [1:0] op;
      logic [5:0] op3;
      logic fpop;
      u = '0;
      op = w[OP_LSB +: 2];
      op3 = w[OP3_LSB +: 6];
      fpop = (op == OP_ARITH) && (op3 == OP3_FPOP1 || op3 == OP3_FPOP2);
      u.valid = 1'b1;
      u.fma = (op == OP_ARITH) && (op3 == OP3_FMA);
      u.rs3 = w[RS3_LSB +: 5];
      u.var_sel = w[VAR_LSB +: 2];
      u.size = w[SIZE_LSB +: 2];
      // Illegal outranks fp_disabled; never the unfinished-op path
      u.illegal = u.fma && (u.size == SIZE_NONE || u.size == SIZE_QUAD);
      u.fp_dis = (u.fma || fpop) && !u.illegal && !fpu_on;
      u.fsr_upd = (u.fma || fpop) && !u.illegal && fpu_on;
      if (u.illegal || u.fp_dis) begin
         u.cls = CLS_NONE;
      end else if (u.fma || fpop) begin
         u.cls = CLS_FP;
      end else if (op == OP_MEM) begin
         u.cls = CLS_MEM;
      end else begin
         u.cls = CLS_ALU;
      end
      u.unit = {u.cls == CLS_FP, odd};
      u.link_we = (op == OP_CALL) || (op == OP_ARITH && op3 == OP3_JMPL);
      u.link_rd = (op == OP_CALL) ? REG_LINK : w[RD_LSB +: 5];
      u.link_val = am ? {32'h0, pc[31:0]} : pc;
      return u;
   endfunction

   dirp_uop_t lu [ISSUE_W];
   logic [ISSUE_W-1:0] lcti;
   logic [ISSUE_W-1:0] lpush;
   logic [ISSUE_W-1:0] lpop;
   logic [63:0] lpc [ISSUE_W];

   for (genvar g = 0; g < ISSUE_W; g++) begin : g_lane
      logic [31:0] w;
      logic ret_form;
      assign w = s.buf_w[g];
      assign lpc[g] = s.buf_pc + 64'(g) * LANE_STEP;
      assign lu[g] = dirp_decode(w, lpc[g], s.ctrl[CTRL_FPU_BIT], s.ctrl[CTRL_AM_BIT],
                                 1'(g % 2));
      assign ret_form = w[IMM_BIT] && w[12:0] == RET_IMM && w[RD_LSB +: 5] == REG_ZERO
                        && (w[RS1_LSB +: 5] == REG_LINK || w[RS1_LSB +: 5] == REG_RET);
      assign lcti[g] = lu[g].link_we;
      assign lpush[g] = lu[g].link_we && lu[g].link_rd == REG_LINK;
      assign lpop[g] = lu[g].link_we && ret_form;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Return address stack

   logic ras_push;
   logic ras_pop;
   logic [63:0] ras_addr;
   logic [63:0] ras_top;

   dirp_ras u_ras (
      .pclk(pclk),
      .presetn(presetn),
      .push(ras_push),
      .pop(ras_pop),
      .push_addr(ras_addr),
      .top(ras_top)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // Next state

   always_comb begin
      logic flush;
      logic stop;
      logic ok;
      logic hit;
      logic [3:0] sel;
      logic [3:0] t;
      logic [7:0] ncse;
      logic [7:0] ngr;
      logic [7:0] nfr;
      logic [7:0] nmp;
      logic [3:0][7:0] nrs;
      flush = 1'b0;
      stop = 1'b0;
      ok = 1'b0;
      hit = 1'b0;
      sel = '0;
      t = s.tail;
      ncse = '0;
      ngr = '0;
      nfr = '0;
      nmp = '0;
      nrs = '0;
      ras_push = 1'b0;
      ras_pop = 1'b0;
      ras_addr = '0;
      next_s = s;
      next_s.dispatch = '0;
      next_s.exc = 1'b0;
      next_s.redirect = 1'b0;
      next_s.pf_req = 1'b0;
      next_s.pred_valid = 1'b0;
      next_s.pready = 1'b0;
      next_s.pslverr = 1'b0;
      for (int i = 0; i < ISSUE_W; i++) begin
         next_s.uo[i].valid = 1'b0;
      end

      // Zero-wait slave: answer is staged in setup, taken in access
      if (psel && !penable) begin
         next_s.pready = 1'b1;
         if (paddr == ADDR_CTRL) begin
            next_s.prdata = {30'h0, s.ctrl};
         end else if (paddr == ADDR_STAT) begin
            next_s.prdata = {8'h0, PIPE_STAGES, 3'h0, s.used[4:0], s.buf_v, 2'h0, s.st};
         end else if (paddr == ADDR_MISP) begin
            next_s.prdata = {16'h0, s.misp_cnt};
         end else if (paddr == ADDR_EXC) begin
            next_s.prdata = {16'h0, s.exc_cnt};
         end else begin
            next_s.prdata = '0;
            next_s.pslverr = 1'b1;
         end
      end
      if (psel && penable && s.pready && pwrite && paddr == ADDR_CTRL) begin
         next_s.ctrl = pwdata[1:0];
      end

      // Station dispatch frees the entry in the cycle it is dispatched
      for (int u = 0; u < UNITS; u++) begin
         if (s.free_rs[u] != RS_TOTAL && src_ready[u] && unit_idle[u]) begin
            next_s.dispatch[u] = 1'b1;
            next_s.free_rs[u] = 8'(s.free_rs[u] + 8'h1);
         end
      end

      // Faults are only recorded here, raised at completion
      if (fault.valid) begin
         next_s.ent_exc[fault.tag] = 1'b1;
      end

      if (cmp.valid && s.used != 8'h0) begin
         hit = s.ent_exc[s.head] || (fault.valid && fault.tag == s.head);
         case (s.ent_cls[s.head])
            CLS_ALU: next_s.free_gr = 8'(s.free_gr + 8'h1);
            CLS_FP: next_s.free_fr = 8'(s.free_fr + 8'h1);
            CLS_MEM: begin
               next_s.free_gr = 8'(s.free_gr + 8'h1);
               next_s.free_mp = 8'(s.free_mp + 8'h1);
            end
            default: ;
         endcase
         next_s.ent_exc[s.head] = 1'b0;
         next_s.head = s.head + 4'h1;
         next_s.used = 8'(s.used - 8'h1);
         if (hit) begin
            flush = 1'b1;
            next_s.exc = 1'b1;
         end else if (cmp.misp) begin
            flush = 1'b1;
            next_s.redirect = 1'b1;
            next_s.redirect_pc = cmp.target;
            next_s.st = ST_BACKUP;
            next_s.wait_cnt = REDIRECT_CYC;
            next_s.misp_cnt = s.misp_cnt + 16'h1;
         end
      end
      // Reliability errors may cut in ahead of completion
      if (ras_err) begin
         flush = 1'b1;
         next_s.exc = 1'b1;
      end
      if (next_s.exc) begin
         next_s.exc_cnt = s.exc_cnt + 16'h1;
      end

      // Issue group stops after its first control transfer
      for (int i = 0; i < ISSUE_W; i++) begin
         if (s.buf_v[i] && !stop) begin
            sel[i] = 1'b1;
            ncse = 8'(ncse + 8'h1);
            if (lcti[i]) begin
               stop = 1'b1;
            end
            case (lu[i].cls)
               CLS_ALU: begin
                  ngr = 8'(ngr + 8'h1);
                  nrs[lu[i].unit] = 8'(nrs[lu[i].unit] + 8'h1);
               end
               CLS_FP: begin
                  nfr = 8'(nfr + 8'h1);
                  nrs[lu[i].unit] = 8'(nrs[lu[i].unit] + 8'h1);
               end
               CLS_MEM: begin
                  ngr = 8'(ngr + 8'h1);
                  nmp = 8'(nmp + 8'h1);
               end
               default: ;
            endcase
         end
      end
      // All-or-nothing allocation against this cycle's free counts
      ok = (s.used + ncse <= CSE_TOTAL) && ngr <= s.free_gr && nfr <= s.free_fr
           && nmp <= s.free_mp;
      for (int u = 0; u < UNITS; u++) begin
         if (nrs[u] > s.free_rs[u]) begin
            ok = 1'b0;
         end
      end
      if (s.st == ST_RUN && ok && sel != 4'h0 && !flush) begin
         for (int i = 0; i < ISSUE_W; i++) begin
            if (sel[i]) begin
               next_s.uo[i] = lu[i];
               next_s.uo[i].tag = t;
               next_s.ent_cls[t] = lu[i].cls;
               next_s.ent_exc[t] = lu[i].illegal || lu[i].fp_dis;
               t = t + 4'h1;
               if (lpush[i]) begin
                  ras_push = 1'b1;
                  ras_addr = lpc[i] + RET_OFFSET;
               end else if (lpop[i]) begin
                  ras_pop = 1'b1;
                  next_s.pred_valid = 1'b1;
                  next_s.pred_pc = ras_top;
               end
            end
         end
         next_s.tail = t;
         next_s.used = 8'(next_s.used + ncse);
         next_s.free_gr = 8'(next_s.free_gr - ngr);
         next_s.free_fr = 8'(next_s.free_fr - nfr);
         next_s.free_mp = 8'(next_s.free_mp - nmp);
         for (int u = 0; u < UNITS; u++) begin
            next_s.free_rs[u] = 8'(next_s.free_rs[u] - nrs[u]);
         end
         next_s.buf_v = s.buf_v & ~sel;
      end

      if (s.st == ST_BACKUP) begin
         next_s.wait_cnt = s.wait_cnt - 2'h1;
         if (s.wait_cnt == 2'h1) begin
            next_s.st = ST_RUN;
         end
      end

      // Fetch decoupled from issue; a full buffer turns demand into prefetch
      if (fetch.valid && s.fetch_ready && !flush) begin
         next_s.buf_v = fetch.lane_valid;
         next_s.buf_pc = fetch.pc;
         next_s.buf_w = fetch.word;
      end else if (fetch.valid && !s.fetch_ready) begin
         next_s.pf_req = 1'b1;
         next_s.pf_pc = fetch.pc;
      end

      // Cache pipeline is not cancelled: outstanding fills still land
      if (flush) begin
         next_s.tail = next_s.head;
         next_s.used = 8'h0;
         next_s.ent_exc = '0;
         next_s.buf_v = '0;
         next_s.free_gr = GR_TOTAL;
         next_s.free_fr = FR_TOTAL;
         next_s.free_mp = MP_TOTAL;
         for (int u = 0; u < UNITS; u++) begin
            next_s.free_rs[u] = RS_TOTAL;
         end
      end
      next_s.fetch_ready = (next_s.buf_v == 4'h0);
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s <= '0;
         s.ctrl <= CTRL_RESET;
         s.free_gr <= GR_TOTAL;
         s.free_fr <= FR_TOTAL;
         s.free_mp <= MP_TOTAL;
         s.free_rs <= {UNITS{RS_TOTAL}};
      end else begin
         s <= next_s;
      end
   end

   assign prdata = s.prdata;
   assign pready = s.pready;
   assign pslverr = s.pslverr;
   assign fetch_ready = s.fetch_ready;
   assign pf_req = s.pf_req;
   assign pf_pc = s.pf_pc;
   assign uop = s.uo;
   assign pred_valid = s.pred_valid;
   assign pred_pc = s.pred_pc;
   assign dispatch = s.dispatch;
   assign exc = s.exc;
   assign redirect_valid = s.redirect;
   assign redirect_pc = s.redirect_pc;

   ////////////////////////////////////////////////////////////////////////////////
   // Checks

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   property p_size_ill;
      uop[0].valid && uop[0].fma && (uop[0].size == SIZE_NONE || uop[0].size == SIZE_QUAD)
         |-> uop[0].illegal && uop[0].cls == CLS_NONE;
   endproperty
   a_size_ill: assert property (p_size_ill) else $error("bad precision not illegal");
   property p_fp_dis;
      uop[0].valid && uop[0].fma && !uop[0].illegal |-> uop[0].fp_dis == !$past(s.ctrl[0]);
   endproperty
   a_fp_dis: assert property (p_fp_dis) else $error("fp_disabled wrong");
   property p_am;
      uop[0].valid && uop[0].link_we && $past(s.ctrl[1]) |-> uop[0].link_val[63:32] == 32'h0;
   endproperty
   a_am: assert property (p_am) else $error("upper link bits not masked");
   property p_misp;
      cmp.valid && cmp.misp && s.used != 8'h0 && !ras_err && !s.ent_exc[s.head]
         && !fault.valid |=> redirect_valid && redirect_pc == $past(cmp.target)
         ##1 (!uop[0].valid) [*2];
   endproperty
   a_misp: assert property (p_misp) else $error("misprediction recovery wrong");
   property p_pf;
      fetch.valid && !fetch_ready |=> pf_req && pf_pc == $past(fetch.pc);
   endproperty
   a_pf: assert property (p_pf) else $error("no prefetch on full buffer");
   property p_cse;
      s.used <= CSE_TOTAL && s.free_gr <= GR_TOTAL;
   endproperty
   a_cse: assert property (p_cse) else $error("resource count out of range");
   property p_flush;
      exc |-> s.used == 8'h0 && s.free_mp == MP_TOTAL && s.buf_v == 4'h0;
   endproperty
   a_flush: assert property (p_flush) else $error("exception left work in flight");
   property p_disp;
      dispatch[0] |-> $past(src_ready[0] && unit_idle[0]);
   endproperty
   a_disp: assert property (p_disp) else $error("dispatch without ready");
   property p_exc;
      exc |-> $past(ras_err || cmp.valid);
   endproperty
   a_exc: assert property (p_exc) else $error("exception out of order");

   c_fma: cover property (uop[0].valid && uop[0].fma && uop[0].fsr_upd);
   c_ret: cover property (pred_valid);
   c_misp: cover property (redirect_valid);
   c_exc: cover property (exc);
endmodule // dirp_core

// [tb/dirp_far.sv]
// Model of the instruction cache and execution units facing the core
`timescale 1ns/100ps
module dirp_far (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic go,
   input wire logic [31:0] word,
   input wire logic [63:0] pc,
   input wire logic misp,
   input wire logic [63:0] target,
   input wire logic fetch_ready,
   output dirp_pkg::dirp_fetch_t fetch,
   output dirp_pkg::dirp_cmp_t cmp
);
   import dirp_pkg::*;
   ////////////////////////////////////////////////////////////////////////////////
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fetch <= '0;
         cmp <= '0;
      end else begin
         // Offer a completion every cycle; the core ignores it when nothing is in flight
         cmp.valid <= 1'b1;
         cmp.misp <= misp;
         cmp.target <= target;
         fetch.word[3:1] <= ~fetch.word[3:1];
         if (go) begin
            fetch.valid <= 1'b1;
            fetch.lane_valid <= 4'h1;
            fetch.pc <= pc;
            fetch.word[0] <= word;
         end else if (fetch.valid && fetch_ready) begin
            fetch.valid <= 1'b0;
         end else if (!fetch.valid) begin
            // Released lines toggle so a stale group is never mistaken for a live one
            fetch.pc <= ~fetch.pc;
            fetch.word[0] <= ~fetch.word[0];
         end
      end
   end
endmodule // dirp_far

// [tb/tb.sv]
// Self-checking bench of the decode, issue and return predict core
`timescale 1ns/100ps
module tb;
   import dirp_pkg::*;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready, pslverr, fetch_ready, pred_valid, exc, redirect_valid, err, pf_req;
   logic [63:0] pred_pc, redirect_pc, pf_pc;
   logic [3:0] dispatch;
   logic [3:0] src_ready = 4'hF;
   logic ras_err = 1'b0;
   dirp_fetch_t fetch;
   dirp_uop_t [3:0] uop;
   dirp_cmp_t cmp;
   dirp_uop_t u;
   logic go = 1'b0;
   logic misp = 1'b0;
   logic [31:0] word = 32'h0;
   logic [31:0] rd;
   logic [63:0] pc = 64'h0;
   logic [63:0] target = 64'h0;
   logic [63:0] pred_seen = 64'h0;
   logic [63:0] redir_seen = 64'h0;
   logic [63:0] exc_seen = 64'h0;
   int failures = 0;
   int checks = 0;
   localparam logic [31:0] CALL_W = {2'h1, 30'h10};
   ////////////////////////////////////////////////////////////////////////////////
   dirp_core dirp_core_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
      .prdata, .pready, .pslverr, .fetch, .fetch_ready, .pf_req, .pf_pc, .uop,
      .pred_valid, .pred_pc, .src_ready, .unit_idle(4'hF), .dispatch, .cmp,
      .fault('0), .ras_err, .exc, .redirect_valid, .redirect_pc);
   dirp_far dirp_far_i (.pclk, .presetn, .go, .word, .pc, .misp, .target,
      .fetch_ready, .fetch, .cmp);
   initial begin
      forever #50 pclk = ~pclk;
   end
   always @(posedge pclk) begin
      if (pred_valid === 1'b1) pred_seen <= pred_pc;
      if (redirect_valid === 1'b1) redir_seen <= redirect_pc;
      if (exc === 1'b1) exc_seen <= exc_seen + 64'h1;
   end
   ////////////////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] fma(input logic [4:0] s3, input logic [1:0] v, sz);
      return {2'h2, 5'h1, OP3_FMA, 5'h2, s3, v, sz, 5'h3};
   endfunction
   function automatic logic [31:0] jmpl(input logic [4:0] rdst, rs1, input logic [12:0] i);
      return {2'h2, rdst, OP3_JMPL, rs1, 1'b1, i};
   endfunction
   task automatic chk(input string name, input logic [63:0] exp, got);
      checks++;
      if (got !== exp) begin
         failures++;
         $display("Error %s expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      for (int n = 0; n < 20; n++) begin
         @(posedge pclk);
         if (pready === 1'b1) break;
      end
      if (pready !== 1'b1) failures++;
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // One group per empty buffer; the trailing wait lets completion and flush settle
   task automatic fet(input logic [31:0] w, input logic [63:0] p);
      repeat (3) @(posedge pclk);
      go <= 1'b1;
      word <= w;
      pc <= p;
      @(posedge pclk);
      go <= 1'b0;
      for (int n = 0; n < 40; n++) begin
         @(posedge pclk);
         if (uop[0].valid === 1'b1) break;
      end
      u = uop[0];
      chk("uop_valid", 64'h1, {63'h0, u.valid});
      repeat (6) @(posedge pclk);
   endtask
   task automatic test_done;
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      repeat (2) @(posedge pclk);
      apb(1'b0, ADDR_CTRL, 32'h0);
      chk("ctrl", 64'h0, rd);
      apb(1'b0, ADDR_STAT, 32'h0);
      chk("stages", 64'hF, rd[23:16]);
      apb(1'b1, 12'h010, 32'hFFFF_FFFF);
      chk("pslverr", 64'h1, err);
      $display("test registers done");
      fet(fma(5'h4, 2'h0, 2'h1), 64'h100);
      chk("fp_dis", 64'h1, u.fp_dis);
      chk("exc_count", 64'h1, exc_seen);
      apb(1'b1, ADDR_CTRL, 32'h1);
      for (int i = 0; i < 4; i++) begin
         fet(fma(5'(i * 7 + 1), 2'(i), 2'(i)), 64'h200);
         chk("fma", 64'h1, u.fma);
         chk("rs3", 64'(i * 7 + 1), u.rs3);
         chk("var_sel", 64'(i), u.var_sel);
         chk("size", 64'(i), u.size);
         chk("illegal", 64'(i == 0 || i == 3), u.illegal);
         chk("fsr_upd", 64'(i == 1 || i == 2), u.fsr_upd);
      end
      chk("exc_count", 64'h3, exc_seen);
      $display("test format done");
      apb(1'b1, ADDR_CTRL, 32'h3);
      fet(CALL_W, 64'h1234_0000_0000_2000);
      chk("link_masked", 64'h2000, u.link_val);
      apb(1'b1, ADDR_CTRL, 32'h1);
      fet(CALL_W, 64'hFFFF_0000_0000_1000);
      chk("link_rd", 64'hF, u.link_rd);
      chk("link_full", 64'hFFFF_0000_0000_1000, u.link_val);
      fet(jmpl(REG_LINK, 5'h5, 13'h0), 64'h4000);
      fet(jmpl(REG_ZERO, REG_LINK, RET_IMM), 64'h6000);
      chk("pred_retl", 64'h4008, pred_seen);
      fet(jmpl(REG_ZERO, REG_RET, RET_IMM), 64'h6100);
      chk("pred_ret", 64'hFFFF_0000_0000_1008, pred_seen);
      for (int i = 1; i <= 9; i++) fet(CALL_W, 64'(i) << 8);
      for (int i = 9; i >= 2; i--) begin
         fet(jmpl(REG_ZERO, REG_LINK, RET_IMM), 64'h8000);
         chk("pred_deep", (64'(i) << 8) + 64'h8, pred_seen);
      end
      $display("test return stack done");
      misp <= 1'b1;
      target <= 64'h9000;
      fet(jmpl(REG_ZERO, REG_RET, RET_IMM), 64'h8800);
      misp <= 1'b0;
      chk("redirect_pc", 64'h9000, redir_seen);
      apb(1'b0, ADDR_MISP, 32'h0);
      chk("misp_count", 64'h1, rd[15:0]);
      apb(1'b0, ADDR_EXC, 32'h0);
      chk("exc_reg", 64'h3, rd[15:0]);
      apb(1'b0, ADDR_STAT, 32'h0);
      chk("used", 64'h0, rd[12:8]);
      $display("test recovery done");
      // Group held past its take: the repeat meets a full buffer and turns into a prefetch
      src_ready <= 4'hE;
      go <= 1'b1;
      word <= 32'h0;
      pc <= 64'hA000;
      repeat (2) @(posedge pclk);
      go <= 1'b0;
      repeat (2) @(posedge pclk);
      chk("pf_req", 64'h1, {63'h0, pf_req});
      chk("pf_pc", 64'hA000, pf_pc);
      src_ready <= 4'hF;
      @(posedge pclk);
      chk("fetch_ready", 64'h0, {63'h0, fetch_ready});
      chk("dispatch_held", 64'h0, {63'h0, dispatch[0]});
      @(posedge pclk);
      chk("dispatch", 64'h1, {63'h0, dispatch[0]});
      ras_err <= 1'b1;
      @(posedge pclk);
      ras_err <= 1'b0;
      repeat (2) @(posedge pclk);
      chk("exc_early", 64'h4, exc_seen);
      $display("test prefetch done");
      test_done;
   end
   initial begin
      repeat (20000) @(posedge pclk);
      failures++;
      test_done;
   end
endmodule // tb
